// >>> legacy_memory_steering_decode.sv
/*
  Host-bridge legacy region decode: shadow attribute, legacy access control,
  low DRAM top and SMM RAM control registers, plus one registered route per cycle.
  Assumes an 8-bit configuration port on clk and same-clock request and strap inputs.
*/
`include "lmsd_regs.svh"
module legacy_memory_steering_decode
  import lmsd_pkg::*;
#(
  parameter int STOLEN_W = 7
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic graphics_vga_on,
  input wire logic [15:0] port_io_window_base,
  input wire logic [15:0] port_io_window_limit,
  input wire logic gfx_stolen_on,
  input wire logic [STOLEN_W-1:0] gfx_stolen_mb,
  input wire logic tseg_on,
  input wire logic [1:0] tseg_size_sel,
  input wire logic req_valid,
  input wire lmsd_source_t req_source,
  input wire logic req_is_io,
  input wire logic req_write,
  input wire logic req_smm,
  input wire logic [31:0] req_addr,
  input wire logic [3:0] req_byte_en,
  output logic route_valid,
  output lmsd_target_t route_target,
  output logic route_hit_shadow,
  output logic route_hit_tseg,
  output logic [11:0] stolen_base_mb,
  output logic [11:0] tseg_base_mb,
  output logic smm_ram_control_open_active,
  output logic smm_ram_control_closed_active,
  output logic smm_ram_control_lock
);
  logic [7:0] attr [3];
  logic [7:0] legacy_ctl;
  logic [4:0] top;
  logic smm_ram_control_open;
  logic smm_ram_control_closed;
  logic global_smm_ram_control_on;
  localparam logic [7:0] SMM_RESET = `LMSD_RST_SMM;

  lmsd_route_if rt ();

  function automatic logic [11:0] mb_sub(input logic [11:0] a, input logic [11:0] b);
    mb_sub = (a > b) ? 12'(a - b) : 12'h000;
  endfunction : mb_sub

  function automatic logic [11:0] tseg_mb(input logic [1:0] sel);
    case (sel)
      2'b00: tseg_mb = `LMSD_TSEG_1MB;
      2'b01: tseg_mb = `LMSD_TSEG_2MB;
      2'b10: tseg_mb = `LMSD_TSEG_8MB;
      default: tseg_mb = 12'h000;
    endcase
  endfunction : tseg_mb

  // register address decode
  wire sel_attr_d8 = cfg_addr == `LMSD_OFF_ATTR_D8;
  wire sel_attr_e0 = cfg_addr == `LMSD_OFF_ATTR_E0;
  wire sel_attr_e8 = cfg_addr == `LMSD_OFF_ATTR_E8;
  wire sel_legacy = cfg_addr == `LMSD_OFF_LEGACY;
  wire sel_top = cfg_addr == `LMSD_OFF_TOP;
  wire sel_smm = cfg_addr == `LMSD_OFF_SMM;

  // boundary in MB: bits 31:27 become MB bits 11:7
  wire [11:0] top_mb = {top, 7'h00};
  wire [11:0] stolen_mb = gfx_stolen_on ? 12'(gfx_stolen_mb) : 12'h000;
  wire tseg_active = tseg_on && global_smm_ram_control_on;
  wire [11:0] tseg_size_mb = tseg_active ? tseg_mb(tseg_size_sel) : 12'h000;
  wire [11:0] next_stolen_base = mb_sub(top_mb, stolen_mb);
  wire [11:0] next_tseg_base = mb_sub(next_stolen_base, tseg_size_mb);

  wire [7:0] smm_read = {1'b0, smm_ram_control_open, smm_ram_control_closed, smm_ram_control_lock, global_smm_ram_control_on,
                         `LMSD_SMM_BASE_SEG};
  wire [7:0] next_rdata;
  assign next_rdata =
    sel_attr_d8 ? attr[0] :
    sel_attr_e0 ? attr[1] :
    sel_attr_e8 ? attr[2] :
    sel_legacy ? legacy_ctl :
    sel_top ? {top, 3'h0} :
    sel_smm ? smm_read : 8'h00;

  // open/close/lock only count while the global enable is set
  wire lock_write = cfg_wr && sel_smm && cfg_wdata[`LMSD_BIT_LOCK] && !smm_ram_control_lock &&
                    (global_smm_ram_control_on || cfg_wdata[`LMSD_BIT_GLOBAL]);
  wire smm_write_ok = cfg_wr && sel_smm && !smm_ram_control_lock;

  assign rt.attr = attr;
  assign rt.memory_hole_on = legacy_ctl[`LMSD_BIT_HOLE];
  assign rt.mono_adapter_present = legacy_ctl[`LMSD_BIT_MONO];
  assign rt.graphics_vga_on = graphics_vga_on;
  assign rt.port_io_window_base = port_io_window_base;
  assign rt.port_io_window_limit = port_io_window_limit;
  assign rt.top_mb = top_mb;
  assign rt.stolen_base_mb = next_stolen_base;
  assign rt.tseg_base_mb = next_tseg_base;
  assign rt.tseg_active = tseg_active;
  assign rt.source = req_source;
  assign rt.is_io = req_is_io;
  assign rt.is_write = req_write;
  assign rt.is_smm = req_smm;
  assign rt.addr = req_addr;
  assign rt.byte_en = req_byte_en;

  lmsd_route_decode u_decode (
    .rt(rt.decoder)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 3; i++) begin
        attr[i] <= `LMSD_RST_ATTR;
      end
    end else if (cfg_wr) begin
      if (sel_attr_d8) begin
        attr[0] <= cfg_wdata & `LMSD_MASK_ATTR;
      end else if (sel_attr_e0) begin
        attr[1] <= cfg_wdata & `LMSD_MASK_ATTR;
      end else if (sel_attr_e8) begin
        attr[2] <= cfg_wdata & `LMSD_MASK_ATTR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      legacy_ctl <= `LMSD_RST_LEGACY;
    end else if (cfg_wr && sel_legacy) begin
      // mono bit with VGA off is illegal; stored as written, decoder falls to hub
      legacy_ctl <= cfg_wdata & `LMSD_MASK_LEGACY;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      top <= `LMSD_RST_TOP;
    end else if (cfg_wr && sel_top && !smm_ram_control_lock) begin
      top <= cfg_wdata[7:3];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      global_smm_ram_control_on <= SMM_RESET[`LMSD_BIT_GLOBAL];
      smm_ram_control_closed <= SMM_RESET[`LMSD_BIT_CLOSE];
    end else if (cfg_wr && sel_smm) begin
      if (!smm_ram_control_lock) begin
        global_smm_ram_control_on <= cfg_wdata[`LMSD_BIT_GLOBAL];
      end
      smm_ram_control_closed <= cfg_wdata[`LMSD_BIT_CLOSE];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      smm_ram_control_open <= SMM_RESET[`LMSD_BIT_OPEN];
      smm_ram_control_lock <= SMM_RESET[`LMSD_BIT_LOCK];
    end else if (lock_write) begin
      // open cannot survive a lock, even if written high with it
      smm_ram_control_lock <= 1'b1;
      smm_ram_control_open <= 1'b0;
    end else if (smm_write_ok) begin
      smm_ram_control_open <= cfg_wdata[`LMSD_BIT_OPEN];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_rd) begin
      cfg_rdata <= next_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      stolen_base_mb <= 12'h000;
      tseg_base_mb <= 12'h000;
      smm_ram_control_open_active <= 1'b0;
      smm_ram_control_closed_active <= 1'b0;
    end else begin
      stolen_base_mb <= next_stolen_base;
      tseg_base_mb <= next_tseg_base;
      smm_ram_control_open_active <= global_smm_ram_control_on && smm_ram_control_open && !smm_ram_control_lock;
      smm_ram_control_closed_active <= global_smm_ram_control_on && smm_ram_control_closed;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      route_valid <= 1'b0;
      route_target <= LMSD_TO_NONE;
      route_hit_shadow <= 1'b0;
      route_hit_tseg <= 1'b0;
    end else begin
      route_valid <= req_valid;
      route_target <= req_valid ? rt.target : LMSD_TO_NONE;
      route_hit_shadow <= req_valid && rt.hit_shadow;
      route_hit_tseg <= req_valid && rt.hit_tseg;
    end
  end
endmodule : legacy_memory_steering_decode

// >>> lmsd_regs.svh
/*
  Register offsets, reset values, field positions and decode ranges of the
  legacy memory steering decode. Assumes inclusion by the two decode modules.
*/
// Functional notes
// - shadow field 00: all reads and writes of the segment go to hub link
// - shadow field 01: reads from DRAM, writes forwarded to hub link
// - shadow field 10: writes to DRAM, reads serviced by hub link
// - shadow field 11: reads and writes both served by DRAM
// - register 94h: bits 5:4 govern 0DC000h segment, 1:0 govern 0D8000h, reset 00
// - register 95h: bits 5:4 govern 0E4000h segment, 1:0 govern 0E0000h
// - register 96h covers 0E8000h-0EFFFFh, upper field upper half, lower field lower
// - legacy control bit 7 opens an unremapped DRAM hole from 15 to 16 MB
// - VGA enable clear: I/O 03BCh-03BFh goes to hub link
// - VGA on, mono absent: 03BCh-03BFh to graphics if inside I/O window
// - mono resources: memory 0B0000h-0B7FFFh, listed ports, A[15:10] ignored
// - mono present: any I/O touching a mono port or alias goes to hub
// - VGA/mono routing table: off/off hub, VGA only graphics, both splits
// - boundary bits 7:3 are address bits 31:27; DRAM only below it
// - below boundary claim 1-64 MB stolen graphics and 1, 2 or 8 MB TSEG
// - stolen base is boundary minus stolen size; TSEG base subtracts TSEG size
// - SMM_RAM_CONTROL open, close and lock act only while global enable is set
// - lock clears open, freezes lock, boundary, global; only reset clears it
// - legacy accesses from hub link or graphics port always go to memory
`ifndef LMSD_REGS_SVH
`define LMSD_REGS_SVH

`define LMSD_OFF_ATTR_D8 8'h94
`define LMSD_OFF_ATTR_E0 8'h95
`define LMSD_OFF_ATTR_E8 8'h96
`define LMSD_OFF_LEGACY 8'h97
`define LMSD_OFF_TOP 8'h9c
`define LMSD_OFF_SMM 8'h9d

`define LMSD_RST_ATTR 8'h00
`define LMSD_RST_LEGACY 8'h00
`define LMSD_RST_TOP 5'h01
`define LMSD_RST_SMM 8'h02

`define LMSD_MASK_ATTR 8'h33
`define LMSD_MASK_LEGACY 8'h81
`define LMSD_BIT_HOLE 7
`define LMSD_BIT_MONO 0
`define LMSD_BIT_OPEN 6
`define LMSD_BIT_CLOSE 5
`define LMSD_BIT_LOCK 4
`define LMSD_BIT_GLOBAL 3
`define LMSD_SMM_BASE_SEG 3'h2
`define LMSD_ATTR_UPPER_POS 4

`define LMSD_SEG_FIRST 6'h36
`define LMSD_SEG_LAST 6'h3b
`define LMSD_HOLE_MB 12'h00f
`define LMSD_VGA_MEM_PAGE 3'h5
`define LMSD_MONO_MEM_HALF 4'hb
`define LMSD_LEGACY_MB 12'h000
`define LMSD_MONO_WIN_LO 16'h03bc
`define LMSD_MONO_WIN_LAST 16'h03bf
`define LMSD_TSEG_1MB 12'h001
`define LMSD_TSEG_2MB 12'h002
`define LMSD_TSEG_8MB 12'h008

`endif

// >>> lmsd_pkg.sv
/*
  Types shared by the legacy memory steering decode modules.
  Assumes lmsd_regs.svh holds the register offsets, reset values and most decode ranges.
*/
package lmsd_pkg;
  typedef enum logic [1:0] {
    LMSD_TO_NONE = 2'b00,
    LMSD_TO_DRAM = 2'b01,
    LMSD_TO_HUB = 2'b10,
    LMSD_TO_GFX = 2'b11
  } lmsd_target_t;

  typedef enum logic [1:0] {
    LMSD_SRC_HOST = 2'b00,
    LMSD_SRC_HUB = 2'b01,
    LMSD_SRC_GFX = 2'b10
  } lmsd_source_t;
endpackage : lmsd_pkg

// >>> lmsd_route_if.sv
/*
  Carrier between the register core and the route decoder.
  Assumes both ends run on the same clock; the decoder is purely combinational.
*/
interface lmsd_route_if;
  import lmsd_pkg::*;
  logic [7:0] attr [3];
  logic memory_hole_on;
  logic mono_adapter_present;
  logic graphics_vga_on;
  logic [15:0] port_io_window_base;
  logic [15:0] port_io_window_limit;
  logic [11:0] top_mb;
  logic [11:0] stolen_base_mb;
  logic [11:0] tseg_base_mb;
  logic tseg_active;
  lmsd_source_t source;
  logic is_io;
  logic is_write;
  logic is_smm;
  logic [31:0] addr;
  logic [3:0] byte_en;
  lmsd_target_t target;
  logic hit_shadow;
  logic hit_tseg;

  modport core (
    output attr, memory_hole_on, mono_adapter_present, graphics_vga_on,
    output port_io_window_base, port_io_window_limit, top_mb, stolen_base_mb,
    output tseg_base_mb, tseg_active, source, is_io, is_write, is_smm, addr, byte_en,
    input target, hit_shadow, hit_tseg
  );
  modport decoder (
    input attr, memory_hole_on, mono_adapter_present, graphics_vga_on,
    input port_io_window_base, port_io_window_limit, top_mb, stolen_base_mb,
    input tseg_base_mb, tseg_active, source, is_io, is_write, is_smm, addr, byte_en,
    output target, hit_shadow, hit_tseg
  );
endinterface : lmsd_route_if

// >>> lmsd_route_decode.sv
/*
  Combinational steering of one processor cycle to DRAM, hub link or graphics.
  Assumes the core registers the result.
*/
`include "lmsd_regs.svh"
module lmsd_route_decode
  import lmsd_pkg::*;
(
  lmsd_route_if.decoder rt
);
  wire [11:0] addr_mb = rt.addr[31:20];
  wire below_1mb = addr_mb == `LMSD_LEGACY_MB;
  wire [5:0] seg = rt.addr[19:14];
  wire in_shadow = below_1mb && seg >= `LMSD_SEG_FIRST && seg <= `LMSD_SEG_LAST;
  wire [5:0] seg_off = seg - `LMSD_SEG_FIRST;
  wire [1:0] seg_reg = seg_off[2:1];
  // upper half segment uses field 5:4, lower half 1:0
  wire [1:0] seg_attr = seg_off[0] ? rt.attr[seg_reg][`LMSD_ATTR_UPPER_POS +: 2]
                                   : rt.attr[seg_reg][1:0];
  wire shadow_dram = rt.is_write ? seg_attr[1] : seg_attr[0];

  wire vga_mem = below_1mb && rt.addr[19:17] == `LMSD_VGA_MEM_PAGE;
  wire mono_mem = below_1mb && rt.addr[19:15] == {`LMSD_MONO_MEM_HALF, 1'b0};

  // aliases fold away A[15:10]
  wire [9:0] io_lo = rt.addr[9:0];
  wire [3:0] io_hit_mono;
  wire [3:0] io_hit_vga;
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      wire [9:0] p = {io_lo[9:2], 2'(b)};
      assign io_hit_mono[b] = rt.byte_en[b] && (p == 10'h3b4 || p == 10'h3b5 ||
        p == 10'h3b8 || p == 10'h3b9 || p == 10'h3ba || p == 10'h3bf);
      assign io_hit_vga[b] = rt.byte_en[b] && ((p >= 10'h3b0 && p <= 10'h3bb) ||
        (p >= 10'h3c0 && p <= 10'h3df));
    end
  endgenerate
  wire touches_mono = |io_hit_mono;
  wire touches_vga = |io_hit_vga;
  wire in_3bc = rt.addr[15:0] >= `LMSD_MONO_WIN_LO && rt.addr[15:0] <= `LMSD_MONO_WIN_LAST;
  wire in_io_window = rt.addr[15:0] >= rt.port_io_window_base &&
                      rt.addr[15:0] <= rt.port_io_window_limit;

  wire in_hole = rt.memory_hole_on && addr_mb == `LMSD_HOLE_MB;
  wire below_top = addr_mb < rt.top_mb;
  wire in_stolen = below_top && addr_mb >= rt.stolen_base_mb;
  wire in_tseg = rt.tseg_active && addr_mb >= rt.tseg_base_mb &&
                 addr_mb < rt.stolen_base_mb;
  wire host = rt.source == LMSD_SRC_HOST;

  assign rt.hit_shadow = in_shadow;
  assign rt.hit_tseg = in_tseg;

  always_comb begin
    rt.target = LMSD_TO_HUB;
    if (rt.is_io) begin
      if (rt.mono_adapter_present && touches_mono) begin
        rt.target = LMSD_TO_HUB;
      end else if (in_3bc) begin
        if (rt.graphics_vga_on && !rt.mono_adapter_present && in_io_window) begin
          rt.target = LMSD_TO_GFX;
        end else begin
          rt.target = LMSD_TO_HUB;
        end
      end else if ((touches_vga || touches_mono) && rt.graphics_vga_on) begin
        rt.target = LMSD_TO_GFX;
      end
    end else if (below_1mb && !host) begin
      rt.target = LMSD_TO_DRAM;
    end else if (mono_mem) begin
      rt.target = (rt.graphics_vga_on && !rt.mono_adapter_present) ? LMSD_TO_GFX
                                                                 : LMSD_TO_HUB;
    end else if (vga_mem) begin
      rt.target = rt.graphics_vga_on ? LMSD_TO_GFX : LMSD_TO_HUB;
    end else if (in_shadow) begin
      rt.target = shadow_dram ? LMSD_TO_DRAM : LMSD_TO_HUB;
    end else if (in_hole || !below_top || in_stolen) begin
      rt.target = LMSD_TO_HUB;
    end else if (in_tseg) begin
      rt.target = rt.is_smm ? LMSD_TO_DRAM : LMSD_TO_HUB;
    end else begin
      rt.target = LMSD_TO_DRAM;
    end
  end
endmodule : lmsd_route_decode

// >>> lmsd_props.sv
/*
  Checker of the steering decode ports: route timing, fixed routes, lock.
  Assumes only the top module's ports; bound to it after the module.
*/
module lmsd_props
  import lmsd_pkg::*;
#(
  parameter int STOLEN_W = 7
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic graphics_vga_on,
  input wire logic req_valid,
  input wire lmsd_source_t req_source,
  input wire logic req_is_io,
  input wire logic req_smm,
  input wire logic [31:0] req_addr,
  input wire logic [3:0] req_byte_en,
  input wire logic route_valid,
  input wire lmsd_target_t route_target,
  input wire logic route_hit_shadow,
  input wire logic [11:0] stolen_base_mb,
  input wire logic [11:0] tseg_base_mb,
  input wire logic smm_ram_control_open_active,
  input wire logic smm_ram_control_lock
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wire host_req = req_valid && req_source == LMSD_SRC_HOST;
  wire host_mem = host_req && !req_is_io;
  wire host_io = host_req && req_is_io && req_byte_en != 4'h0;
  // 0d8000h..0effffh in 32 KB steps
  wire shadow_addr = req_addr[31:15] >= 17'h0001b && req_addr[31:15] <= 17'h0001d;

  a_route_pulse: assert property (req_valid |=> route_valid)
    else $error("no route after request");
  a_idle_quiet: assert property (!req_valid |=> !route_valid && route_target == LMSD_TO_NONE)
    else $error("route without request");
  a_shadow_flag:
    assert property (req_valid && !req_is_io && shadow_addr |=> route_hit_shadow)
    else $error("shadow hit not flagged");
  a_nonhost_legacy:
    assert property (req_valid && req_source != LMSD_SRC_HOST && !req_is_io && shadow_addr
      |=> route_target == LMSD_TO_DRAM)
    else $error("non-host legacy access not sent to memory");
  a_mono_io_hub:
    assert property (host_io && !graphics_vga_on && req_addr[9:4] == 6'h3b
      |=> route_target == LMSD_TO_HUB)
    else $error("3bxh port not sent to hub with vga off");
  a_vga_io_gfx:
    assert property (host_io && graphics_vga_on && req_addr[9:5] == 5'h1e
      |=> route_target == LMSD_TO_GFX)
    else $error("vga port not sent to graphics");
  a_vga_mem_gfx:
    assert property (host_mem && req_addr[31:16] == 16'h000a && graphics_vga_on && !req_smm
      && !smm_ram_control_open_active |=> route_target == LMSD_TO_GFX)
    else $error("vga memory not sent to graphics");
  a_lock_sticky: assert property (smm_ram_control_lock |=> smm_ram_control_lock)
    else $error("lock dropped without reset");
  a_lock_shuts_open: assert property (smm_ram_control_lock |=> !smm_ram_control_open_active)
    else $error("open active while locked");
  a_tseg_below: assert property (tseg_base_mb <= stolen_base_mb)
    else $error("tseg base above stolen base");
endmodule : lmsd_props

bind legacy_memory_steering_decode lmsd_props #(.STOLEN_W(STOLEN_W)) u_props (
  .clk, .reset, .graphics_vga_on, .req_valid, .req_source, .req_is_io, .req_smm, .req_addr,
  .req_byte_en, .route_valid, .route_target, .route_hit_shadow, .stolen_base_mb,
  .tseg_base_mb, .smm_ram_control_open_active, .smm_ram_control_lock
);

// >>> lmsd_host_model.sv
/*
  Processor side model: configuration cycles and steered requests.
  Assumes the decode answers one cycle after each strobe.
*/
module lmsd_host_model
  import lmsd_pkg::*;
(
  input wire logic clk,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_addr,
  output logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  output logic req_valid,
  output lmsd_source_t req_source,
  output logic req_is_io,
  output logic req_write,
  output logic req_smm,
  output logic [31:0] req_addr,
  output logic [3:0] req_byte_en,
  input wire lmsd_target_t route_target,
  input wire logic route_hit_tseg
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {cfg_wr, cfg_rd, req_valid, req_is_io, req_write, req_smm} = '0;
    {cfg_addr, cfg_wdata} = 16'h0000;
    req_source = LMSD_SRC_HOST;
    req_addr = 32'h0;
    req_byte_en = 4'h0;
  end
  // released fields show inverted values so stale data never looks valid
  task cfg(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    #1;
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {wr, !wr, a, d};
    @(posedge clk);
    #1;
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {2'b00, ~a, ~d};
    q = cfg_rdata;
  endtask : cfg
  task req(input lmsd_source_t s, input logic io, input logic w, input logic m,
           input logic [31:0] a, input logic [3:0] be, output lmsd_target_t t, output logic ts);
    @(posedge clk);
    #1;
    {req_valid, req_is_io, req_write, req_smm, req_addr, req_byte_en} = {1'b1, io, w, m, a, be};
    req_source = s;
    @(posedge clk);
    #1;
    {req_valid, req_addr, req_byte_en} = {1'b0, ~a, ~be};
    t = route_target;
    ts = route_hit_tseg;
  endtask : req
endmodule : lmsd_host_model

// >>> tb_top.sv
/*
  Self-checking bench of the legacy steering decode.
  Assumes the host model drives all strobes; straps are driven here.
*/
module tb_top
  import lmsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, reset = 1, graphics_vga_on = 0, gfx_stolen_on = 0, tseg_on = 0;
  logic [15:0] port_io_window_base = 16'h0300, port_io_window_limit = 16'h03ff;
  logic [6:0] gfx_stolen_mb = 7'h08;
  logic [1:0] tseg_size_sel = 2'h0;
  logic cfg_wr, cfg_rd, req_valid, req_is_io, req_write, req_smm, route_valid;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, q;
  lmsd_source_t req_source;
  lmsd_target_t route_target;
  logic [31:0] req_addr;
  logic [3:0] req_byte_en;
  logic route_hit_shadow, route_hit_tseg, smm_ram_control_open_active, smm_ram_control_closed_active, smm_ram_control_lock;
  logic [11:0] stolen_base_mb, tseg_base_mb;
  logic ts;
  int miscompares = 0, checks_done = 0;
  logic [7:0] offs [7] = '{8'h94, 8'h95, 8'h96, 8'h97, 8'h9c, 8'h9d, 8'h98};
  logic [7:0] rstv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h02, 8'h00};
  logic [11:0] tsz [3] = '{12'h001, 12'h002, 12'h008};

  always #50 clk = ~clk;
  legacy_memory_steering_decode #(.STOLEN_W(7)) dut (.clk, .reset, .cfg_wr, .cfg_rd,
    .cfg_addr, .cfg_wdata, .cfg_rdata, .graphics_vga_on, .port_io_window_base,
    .port_io_window_limit, .gfx_stolen_on, .gfx_stolen_mb, .tseg_on, .tseg_size_sel,
    .req_valid, .req_source, .req_is_io, .req_write, .req_smm, .req_addr, .req_byte_en,
    .route_valid, .route_target, .route_hit_shadow, .route_hit_tseg, .stolen_base_mb,
    .tseg_base_mb, .smm_ram_control_open_active, .smm_ram_control_closed_active, .smm_ram_control_lock);
  lmsd_host_model host (.clk, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata,
    .req_valid, .req_source, .req_is_io, .req_write, .req_smm, .req_addr, .req_byte_en,
    .route_target, .route_hit_tseg);

  task tally_and_finish;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task check(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [7:0] d);
    host.cfg(1'b1, a, d, q);
  endtask : wr
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    host.cfg(1'b0, a, 8'h00, q);
    check(12'(q), 12'(e));
  endtask : rd_chk
  task rt(input lmsd_source_t s, input logic io, input logic w, input logic m,
          input logic [31:0] a, input logic [3:0] be, input lmsd_target_t e);
    lmsd_target_t t;
    host.req(s, io, w, m, a, be, t, ts);
    check(12'(t), 12'(e));
  endtask : rt
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  initial begin
    repeat (5000) @(posedge clk);
    $display("[FAIL] %0t: run limit reached", $time);
    miscompares++;
    tally_and_finish;
  end
  initial begin
    tick(3);
    reset = 0;
    for (int i = 0; i < 7; i++) rd_chk(offs[i], rstv[i]);
    graphics_vga_on = 1;
    for (int i = 0; i < 4; i++) begin
      wr(offs[i], 8'hff);
      rd_chk(offs[i], i == 3 ? 8'h81 : 8'h33);
    end
    wr(8'h97, 8'h00);
    // codes run 11 down to 00 so other initiators are tried against a closed segment
    for (int s = 0; s < 6; s++) begin
      for (int c = 3; c >= 0; c--) begin
        wr(8'h94 + 8'(s / 2), 8'(c << (4 * (s % 2))));
        rt(LMSD_SRC_HOST, 0, 0, 0, 32'h000d8100 + 32'(s) * 32'h4000, 4'h0,
           c[0] ? LMSD_TO_DRAM : LMSD_TO_HUB);
        rt(LMSD_SRC_HOST, 0, 1, 0, 32'h000d8100 + 32'(s) * 32'h4000, 4'h0,
           c[1] ? LMSD_TO_DRAM : LMSD_TO_HUB);
      end
      rt((s % 2) ? LMSD_SRC_GFX : LMSD_SRC_HUB, 0, 0, 0, 32'h000d8100 + 32'(s) * 32'h4000,
         4'h0, LMSD_TO_DRAM);
    end
    rt(LMSD_SRC_HOST, 0, 0, 0, 32'h00f00000, 4'h0, LMSD_TO_DRAM);
    wr(8'h97, 8'h80);
    rt(LMSD_SRC_HOST, 0, 0, 0, 32'h00f00000, 4'h0, LMSD_TO_HUB);
    rt(LMSD_SRC_HOST, 0, 1, 0, 32'h00fffffc, 4'h0, LMSD_TO_HUB);
    rt(LMSD_SRC_HOST, 0, 0, 0, 32'h01000000, 4'h0, LMSD_TO_DRAM);
    wr(8'h97, 8'h00);
    rt(LMSD_SRC_HOST, 0, 0, 0, 32'h07f00000, 4'h0, LMSD_TO_DRAM);
    rt(LMSD_SRC_HOST, 0, 0, 0, 32'h08000000, 4'h0, LMSD_TO_HUB);
    wr(8'h9c, 8'h10);
    rd_chk(8'h9c, 8'h10);
    rt(LMSD_SRC_HOST, 0, 0, 0, 32'h08000000, 4'h0, LMSD_TO_DRAM);
    rt(LMSD_SRC_HOST, 0, 0, 0, 32'h10000000, 4'h0, LMSD_TO_HUB);
    gfx_stolen_on = 1;
    tseg_on = 1;
    wr(8'h9d, 8'h08);
    for (int k = 0; k < 3; k++) begin
      tseg_size_sel = 2'(k);
      tick(2);
      check(stolen_base_mb, 12'h0f8);
      check(tseg_base_mb, 12'h0f8 - tsz[k]);
      rt(LMSD_SRC_HOST, 0, 0, 1, 32'(12'h0f8 - tsz[k]) << 20, 4'h0, LMSD_TO_DRAM);
      check(12'(ts), 12'h001);
      rt(LMSD_SRC_HOST, 0, 0, 0, 32'(12'h0f8 - tsz[k]) << 20, 4'h0, LMSD_TO_HUB);
    end
    rt(LMSD_SRC_HOST, 0, 0, 0, 32'h0f900000, 4'h0, LMSD_TO_HUB);
    tseg_size_sel = 2'h3;
    tick(2);
    check(tseg_base_mb, 12'h0f8);
    graphics_vga_on = 0;
    rt(LMSD_SRC_HOST, 1, 0, 0, 32'h000003bc, 4'h1, LMSD_TO_HUB);
    rt(LMSD_SRC_HOST, 0, 0, 0, 32'h000a0000, 4'h0, LMSD_TO_HUB);
    graphics_vga_on = 1;
    rt(LMSD_SRC_HOST, 1, 0, 0, 32'h000003bc, 4'h8, LMSD_TO_GFX);
    rt(LMSD_SRC_HOST, 0, 0, 0, 32'h000b0000, 4'h0, LMSD_TO_GFX);
    port_io_window_base = 16'h1000;
    port_io_window_limit = 16'h1fff;
    rt(LMSD_SRC_HOST, 1, 1, 0, 32'h000003bc, 4'h1, LMSD_TO_HUB);
    wr(8'h97, 8'h01);
    rt(LMSD_SRC_HOST, 1, 0, 0, 32'h000003b4, 4'hf, LMSD_TO_HUB);
    rt(LMSD_SRC_HOST, 1, 0, 0, 32'h00007fb8, 4'h1, LMSD_TO_HUB);
    rt(LMSD_SRC_HOST, 1, 0, 0, 32'h000003c0, 4'h1, LMSD_TO_GFX);
    rt(LMSD_SRC_HOST, 0, 0, 0, 32'h000b0000, 4'h0, LMSD_TO_HUB);
    rt(LMSD_SRC_HOST, 0, 1, 0, 32'h000a0000, 4'h0, LMSD_TO_GFX);
    wr(8'h9d, 8'h40);
    tick(2);
    check(12'(smm_ram_control_open_active), 12'h000);
    wr(8'h9d, 8'h48);
    tick(2);
    check(12'(smm_ram_control_open_active), 12'h001);
    wr(8'h9d, 8'h28);
    tick(2);
    check(12'(smm_ram_control_closed_active), 12'h001);
    wr(8'h9d, 8'h08);
    wr(8'h9d, 8'h18);
    wr(8'h9d, 8'h48);
    wr(8'h9c, 8'h20);
    tick(2);
    check({smm_ram_control_lock, 11'(smm_ram_control_open_active)}, 12'h800);
    rd_chk(8'h9c, 8'h10);
    rd_chk(8'h9d, 8'h1a);
    reset = 1;
    tick(1);
    reset = 0;
    tick(1);
    check(12'(smm_ram_control_lock), 12'h000);
    rd_chk(8'h9d, 8'h02);
    tally_and_finish;
  end
endmodule : tb_top
